/* verilog/gsl_pkg.sv */
// package of offsets, fields and types for the gpio set/clear/latch port
package gsl_pkg;
   localparam int          GSL_PINS          = 32;
   localparam int          GSL_AW            = 12;
   // register byte offsets
   localparam logic [11:0] GSL_OUT_SET       = 12'h508;
   localparam logic [11:0] GSL_OUT_CLR       = 12'h50C;
   localparam logic [11:0] GSL_IN_STATE      = 12'h510;
   localparam logic [11:0] GSL_OE_MASK       = 12'h514;
   localparam logic [11:0] GSL_OE_SET        = 12'h518;
   localparam logic [11:0] GSL_OE_CLR        = 12'h51C;
   localparam logic [11:0] GSL_HIT_LATCH     = 12'h520;
   localparam logic [11:0] GSL_WAKE_SEL      = 12'h524;
   localparam logic [11:0] GSL_INT_STATUS    = 12'h600;
   localparam logic [11:0] GSL_INT_MASK      = 12'h604;
   localparam logic [11:0] GSL_SENSE_LO      = 12'h608;
   localparam logic [11:0] GSL_SENSE_HI      = 12'h60C;
   // reset values and fields
   localparam logic [31:0] GSL_RST_ZERO      = 32'h0000_0000;
   localparam logic [31:0] GSL_UNMAPPED_RD   = 32'h0000_0000;
   localparam int          GSL_WAKE_SEL_BIT  = 0;
   localparam logic [1:0]  GSL_SENSE_OFF     = 2'h0;
   localparam logic [1:0]  GSL_SENSE_HIGH    = 2'h2;
   localparam logic [1:0]  GSL_SENSE_LOW     = 2'h3;
   localparam int          GSL_IRQ_HIT       = 0;
   localparam int          GSL_IRQ_WAKE      = 1;
   localparam int          GSL_IRQ_W         = 2;

   // one avalon request
   typedef struct packed {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } gsl_req_s;

   // bus answer states
   typedef enum logic [1:0] {
      GSL_ST_IDLE = 2'b01,
      GSL_ST_ACK  = 2'b10
   } gsl_state_e;
endpackage

/* verilog/gsl_sense.sv */
// per-pin level sense and hit latch
`timescale 1ns/1ps
`default_nettype none
module gsl_sense (
   input  wire logic        mclk_i,     // system clock
   input  wire logic        rst_i,      // async reset, high
   input  wire logic [31:0] pins_i,     // sampled pin levels
   input  wire logic [63:0] sense_cfg_i,// two bits per pin
   input  wire logic [31:0] clr_i,      // write-one clear mask
   input  wire logic        clr_we_i,   // clear strobe
   output logic      [31:0] hit_o,      // live sense per pin
   output logic      [31:0] latch_o     // latched hits
);
   logic [31:0] latch_reg;
   logic [31:0] latch_next;

   // level criterion per pin
   always_comb
   begin
      for (int i = 0; i < gsl_pkg::GSL_PINS; i++)
      begin
         case (sense_cfg_i[2*i +: 2])
            gsl_pkg::GSL_SENSE_HIGH: hit_o[i] = pins_i[i];  // [RULE11]
            gsl_pkg::GSL_SENSE_LOW:  hit_o[i] = ~pins_i[i]; // [RULE11]
            default:                 hit_o[i] = 1'b0;
         endcase
      end
   end

   // set wins over a same-cycle clear
   assign latch_next = (latch_reg & ~(clr_we_i ? clr_i : 32'h0000_0000)) | hit_o; // [RULE8] [RULE13]

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         latch_reg <= gsl_pkg::GSL_RST_ZERO;
      else
         latch_reg <= latch_next;
   end
   assign latch_o = latch_reg;

   AST_LATCH_SET: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE8]
      hit_o != 32'h0000_0000 |=> (latch_o & $past(hit_o)) == $past(hit_o))
      else $error("sensed pin not latched");
   AST_LATCH_CLR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE13]
      clr_we_i && hit_o == 32'h0000_0000 |=> (latch_o & $past(clr_i)) == 32'h0000_0000)
      else $error("latch bit not cleared");
endmodule
`default_nettype wire

/* verilog/gsl_irq.sv */
// sticky event status with mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module gsl_irq (
   input  wire logic       mclk_i,   // system clock
   input  wire logic       rst_i,    // async reset, high
   input  wire logic [1:0] event_i,  // event pulses
   input  wire logic [1:0] w1c_i,    // write-one clear data
   input  wire logic       w1c_we_i, // status write strobe
   input  wire logic [1:0] mask_i,   // enable mask
   output logic      [1:0] status_o, // sticky status
   output logic            irq_o     // level interrupt
);
   logic [1:0] status_reg;
   logic [1:0] status_next;

   // set wins over clear
   assign status_next = (status_reg & ~(w1c_we_i ? w1c_i : 2'h0)) | event_i;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         status_reg <= 2'h0;
      else
         status_reg <= status_next;
   end
   assign status_o = status_reg;
   assign irq_o    = |(status_reg & mask_i);

   // written ones clear when no event competes, events always stick
   AST_IRQ_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
      w1c_we_i && event_i == 2'h0 |=> (status_o & $past(w1c_i)) == 2'h0)
      else $error("status bit not cleared");
   AST_IRQ_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
      event_i != 2'h0 |=> (status_o & $past(event_i)) == $past(event_i))
      else $error("event not recorded");
endmodule
`default_nettype wire

/* verilog/gsl_port.sv */
// top of the 32-pin gpio port with avalon register slave
// How it works
// RULE1: reading output_set or output_clear returns the output level register.
// RULE2: writing output_set drives high each output bit written as one.
// RULE3: writing output_clear drives low each output bit written as one.
// RULE4: the output_enable_mask holds one direction bit per pin, one for output, reset zero.
// RULE5: writing output_enable_set makes each pin written as one an output.
// RULE6: writing output_enable_clear makes each pin written as one an input.
// RULE7: reading output_enable_set or output_enable_clear returns the output enable mask.
// RULE8: the sense_hit_latch sets a pin bit when its level criterion is met and holds it.
// RULE9: with wake_signal_select bit 0 low, wake follows the live per-pin sense signals.
// RULE10: with wake_signal_select high, wake follows the latched hits instead.
// RULE11: the level-watch field is 0 off, 2 sense high, 3 sense low.
// RULE12: the pin_setup direction bit is the very same storage as the output enable mask.
// RULE13: writing a one to a sense_hit_latch bit clears it, zero leaves it.
// RULE14: the input register reads the sampled pin levels and ignores writes.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module gsl_port (
   input  wire logic        mclk_i,              // 200 MHz clock
   input  wire logic        rst_i,               // async reset, high
   input  wire logic [11:0] avs_address_i,       // byte address
   input  wire logic        avs_read_i,          // read request
   input  wire logic        avs_write_i,         // write request
   input  wire logic [31:0] avs_writedata_i,     // write data
   input  wire logic [3:0]  avs_byteenable_i,    // byte lanes
   output logic      [31:0] avs_readdata_o,      // read data
   output logic             avs_waitrequest_o,   // stall
   input  wire logic [31:0] pin_in_i,            // pin levels
   output logic      [31:0] pin_out_o,           // pin drive level
   output logic      [31:0] pin_oe_n_o,          // drive enable, low drives
   input  wire logic [31:0] pin_setup_dir_i,     // pin_setup direction data
   input  wire logic [31:0] pin_setup_dir_we_i,  // pin_setup direction write
   output logic      [31:0] pin_setup_dir_o,     // pin_setup direction read
   output logic             wake_o,              // port wake signal
   output logic             irq_o                // level interrupt
);
   gsl_pkg::gsl_req_s   req;
   gsl_pkg::gsl_state_e state_reg;
   gsl_pkg::gsl_state_e state_next;
   logic [31:0] out_reg;
   logic [31:0] out_next;
   logic [31:0] oe_reg;
   logic [31:0] oe_next;
   logic [31:0] in_reg;
   logic        wsel_reg;
   logic [1:0]  imask_reg;
   logic [63:0] sense_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] hit;
   logic [31:0] latch;
   logic [1:0]  istatus;
   logic [1:0]  events;
   logic        wake_next;
   logic        wake_reg;
   logic        take;
   logic        wr;
   logic        rd;
   wire  logic  w_oset   = wr && req.address == gsl_pkg::GSL_OUT_SET;
   wire  logic  w_oclr   = wr && req.address == gsl_pkg::GSL_OUT_CLR;
   wire  logic  w_oe     = wr && req.address == gsl_pkg::GSL_OE_MASK;
   wire  logic  w_oeset  = wr && req.address == gsl_pkg::GSL_OE_SET;
   wire  logic  w_oeclr  = wr && req.address == gsl_pkg::GSL_OE_CLR;
   wire  logic  w_latch  = wr && req.address == gsl_pkg::GSL_HIT_LATCH;
   wire  logic  w_wsel   = wr && req.address == gsl_pkg::GSL_WAKE_SEL;
   wire  logic  w_istat  = wr && req.address == gsl_pkg::GSL_INT_STATUS;
   wire  logic  w_imask  = wr && req.address == gsl_pkg::GSL_INT_MASK;
   wire  logic  w_slo    = wr && req.address == gsl_pkg::GSL_SENSE_LO;
   wire  logic  w_shi    = wr && req.address == gsl_pkg::GSL_SENSE_HI;

   // expand byte enables to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++)
         m[8*b +: 8] = {8{be[b]}};
      return m;
   endfunction

   // merge a masked write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [31:0] m);
      return (old & ~m) | (d & m);
   endfunction

   // request bundle
   assign req.address    = avs_address_i;
   assign req.read       = avs_read_i;
   assign req.write      = avs_write_i;
   assign req.writedata  = avs_writedata_i;
   assign req.byteenable = avs_byteenable_i;

   // one wait cycle, then accept on the ack state
   assign take  = state_reg == gsl_pkg::GSL_ST_ACK;
   assign wr    = take && req.write;
   assign rd    = take && req.read;
   assign wmask = be_mask(req.byteenable);
   assign wbits = req.writedata & wmask;
   assign avs_waitrequest_o = (req.read || req.write) && !take;

   always_comb
   begin
      case (state_reg)
         gsl_pkg::GSL_ST_IDLE: state_next = (req.read || req.write) ? gsl_pkg::GSL_ST_ACK
                                                                     : gsl_pkg::GSL_ST_IDLE;
         gsl_pkg::GSL_ST_ACK:  state_next = gsl_pkg::GSL_ST_IDLE;
         default:              state_next = gsl_pkg::GSL_ST_IDLE;
      endcase
   end

   // output level: set and clear by written ones
   assign out_next = w_oset ? (out_reg | wbits)            // [RULE2]
                   : w_oclr ? (out_reg & ~wbits)           // [RULE3]
                   : out_reg;

   // direction: one storage for mask, set, clear and pin_setup
   assign oe_next = w_oe    ? merge(oe_reg, req.writedata, wmask)  // [RULE4]
                  : w_oeset ? (oe_reg | wbits)                     // [RULE5]
                  : w_oeclr ? (oe_reg & ~wbits)                    // [RULE6]
                  : merge(oe_reg, pin_setup_dir_i, pin_setup_dir_we_i); // [RULE12]

   // read data selection
   assign rdata_next =
        (req.address == gsl_pkg::GSL_OUT_SET || req.address == gsl_pkg::GSL_OUT_CLR) ? out_reg // [RULE1]
      : (req.address == gsl_pkg::GSL_IN_STATE)   ? in_reg                                      // [RULE14]
      : (req.address == gsl_pkg::GSL_OE_MASK || req.address == gsl_pkg::GSL_OE_SET
         || req.address == gsl_pkg::GSL_OE_CLR)  ? oe_reg                                      // [RULE7]
      : (req.address == gsl_pkg::GSL_HIT_LATCH)  ? latch
      : (req.address == gsl_pkg::GSL_WAKE_SEL)   ? {31'h0000_0000, wsel_reg}
      : (req.address == gsl_pkg::GSL_INT_STATUS) ? {30'h0000_0000, istatus}
      : (req.address == gsl_pkg::GSL_INT_MASK)   ? {30'h0000_0000, imask_reg}
      : (req.address == gsl_pkg::GSL_SENSE_LO)   ? sense_reg[31:0]
      : (req.address == gsl_pkg::GSL_SENSE_HI)   ? sense_reg[63:32]
      : gsl_pkg::GSL_UNMAPPED_RD;

   // wake source select
   assign wake_next = wsel_reg ? |latch  // [RULE10]
                               : |hit;   // [RULE9]

   // rising wake and new latch hits raise events
   assign events[gsl_pkg::GSL_IRQ_HIT]  = |(hit & ~latch);
   assign events[gsl_pkg::GSL_IRQ_WAKE] = wake_next && !wake_reg;

   // bus state and data registers
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= gsl_pkg::GSL_ST_IDLE;
         out_reg   <= gsl_pkg::GSL_RST_ZERO;
         oe_reg    <= gsl_pkg::GSL_RST_ZERO;
         rdata_reg <= gsl_pkg::GSL_RST_ZERO;
         in_reg    <= gsl_pkg::GSL_RST_ZERO;
         wake_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         out_reg   <= out_next;
         oe_reg    <= oe_next;
         in_reg    <= pin_in_i;   // [RULE14]
         wake_reg  <= wake_next;
         if (!take)
            rdata_reg <= rdata_next;
      end
   end

   // configuration registers
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wsel_reg  <= 1'b0;
         imask_reg <= 2'h0;
         sense_reg <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         if (w_wsel && req.byteenable[0])
            wsel_reg <= req.writedata[gsl_pkg::GSL_WAKE_SEL_BIT];
         if (w_imask && req.byteenable[0])
            imask_reg <= req.writedata[1:0];
         if (w_slo)
            sense_reg[31:0] <= merge(sense_reg[31:0], req.writedata, wmask);
         if (w_shi)
            sense_reg[63:32] <= merge(sense_reg[63:32], req.writedata, wmask);
      end
   end

   gsl_sense u_sense (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .pins_i      (in_reg),
      .sense_cfg_i (sense_reg),
      .clr_i       (wbits),
      .clr_we_i    (w_latch),
      .hit_o       (hit),
      .latch_o     (latch)
   );

   gsl_irq u_irq (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .event_i  (events),
      .w1c_i    (req.writedata[1:0]),
      .w1c_we_i (w_istat && req.byteenable[0]),
      .mask_i   (imask_reg),
      .status_o (istatus),
      .irq_o    (irq_o)
   );

   assign avs_readdata_o  = rdata_reg;
   assign pin_out_o       = out_reg;
   assign pin_oe_n_o      = ~oe_reg;
   assign pin_setup_dir_o = oe_reg;
   assign wake_o          = wake_reg;

   sequence s_acc_oset;
      avs_write_i && avs_address_i == gsl_pkg::GSL_OUT_SET && !avs_waitrequest_o;
   endsequence
   AST_OUT_SET: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE2]
      s_acc_oset |=> (pin_out_o & $past(avs_writedata_i & be_mask(avs_byteenable_i)))
                    == $past(avs_writedata_i & be_mask(avs_byteenable_i)))
      else $error("output set bit not high");
   AST_OUT_CLR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE3]
      avs_write_i && avs_address_i == gsl_pkg::GSL_OUT_CLR && !avs_waitrequest_o
      |=> (pin_out_o & $past(avs_writedata_i & be_mask(avs_byteenable_i))) == 32'h0000_0000)
      else $error("output clear bit not low");
   // bits written as zero keep their level
   AST_OUT_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE2]
      w_oset |=> (pin_out_o & ~$past(wbits)) == ($past(pin_out_o) & ~$past(wbits)))
      else $error("output set touched a zero bit");
   AST_OUT_CLR_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE3]
      w_oclr |=> (pin_out_o & ~$past(wbits)) == ($past(pin_out_o) & ~$past(wbits)))
      else $error("output clear touched a zero bit");
   AST_RD_OUT: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE1]
      avs_read_i && !avs_waitrequest_o && (avs_address_i == gsl_pkg::GSL_OUT_SET
      || avs_address_i == gsl_pkg::GSL_OUT_CLR) |-> avs_readdata_o == $past(pin_out_o))
      else $error("output read mismatch");
   AST_RD_OE: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE7]
      avs_read_i && !avs_waitrequest_o && (avs_address_i == gsl_pkg::GSL_OE_SET
      || avs_address_i == gsl_pkg::GSL_OE_CLR) |-> avs_readdata_o == $past(oe_reg))
      else $error("direction read mismatch");
   AST_OE_SET: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE5]
      avs_write_i && avs_address_i == gsl_pkg::GSL_OE_SET && !avs_waitrequest_o
      |=> (oe_reg & $past(avs_writedata_i & be_mask(avs_byteenable_i)))
          == $past(avs_writedata_i & be_mask(avs_byteenable_i)))
      else $error("direction set failed");
   AST_OE_CLR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE6]
      avs_write_i && avs_address_i == gsl_pkg::GSL_OE_CLR && !avs_waitrequest_o
      |=> (oe_reg & $past(avs_writedata_i & be_mask(avs_byteenable_i))) == 32'h0000_0000)
      else $error("direction clear failed");
   // direction bits written as zero keep their value
   AST_OE_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE5]
      w_oeset |=> (oe_reg & ~$past(wbits)) == ($past(oe_reg) & ~$past(wbits)))
      else $error("direction set touched a zero bit");
   AST_OE_CLR_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE6]
      w_oeclr |=> (oe_reg & ~$past(wbits)) == ($past(oe_reg) & ~$past(wbits)))
      else $error("direction clear touched a zero bit");
   // whole-mask write lands on the enabled lanes
   AST_OE_MASK: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE4]
      w_oe |=> ((oe_reg ^ $past(req.writedata)) & $past(wmask)) == 32'h0000_0000)
      else $error("direction mask write lost");
   // pin_setup write reaches the shared direction storage when the bus is quiet
   AST_SETUP_DIR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE12]
      !(w_oe || w_oeset || w_oeclr) |=> ((pin_setup_dir_o ^ $past(pin_setup_dir_i))
      & $past(pin_setup_dir_we_i)) == 32'h0000_0000)
      else $error("pin_setup direction write lost");
   AST_WAKE_LIVE: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE9]
      !wsel_reg |=> wake_o == $past(|hit))
      else $error("live wake mismatch");
   AST_WAKE_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE10]
      wsel_reg |=> wake_o == $past(|latch))
      else $error("latched wake mismatch");
   AST_LATCH_RD: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE8]
      rd && req.address == gsl_pkg::GSL_HIT_LATCH |-> avs_readdata_o == $past(latch))
      else $error("latch read mismatch");
   AST_IN_RD: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE14]
      avs_read_i && !avs_waitrequest_o && avs_address_i == gsl_pkg::GSL_IN_STATE
      |-> avs_readdata_o == $past(in_reg))
      else $error("input read mismatch");
   // a write to the input register changes no state
   AST_IN_IGNORE: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE14]
      wr && req.address == gsl_pkg::GSL_IN_STATE && pin_setup_dir_we_i == 32'h0000_0000
      |=> pin_out_o == $past(pin_out_o) && oe_reg == $past(oe_reg))
      else $error("input write changed state");
   // exactly one wait cycle before every answer
   sequence s_req_idle;
      (avs_read_i || avs_write_i) && state_reg == gsl_pkg::GSL_ST_IDLE;
   endsequence
   AST_ACK_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_req_idle |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("answer not after one wait cycle");
endmodule
`default_nettype wire

/* sim/gsl_pins_model.sv */
// board side of the port pins: driven pins echo, others follow the board
`timescale 1ns/1ps
`default_nettype none
module gsl_pins_model (
   input  wire logic [31:0] drv_i,  // port drive level
   input  wire logic [31:0] oe_n_i, // drive enable, low drives
   input  wire logic [31:0] ext_i,  // level forced by board circuitry
   output logic      [31:0] pin_o   // resolved wire level
);
   // a driven pin shows the port's level, a released one the board's
   always_comb
   begin
      pin_o = (~oe_n_i & drv_i) | (oe_n_i & ext_i);
   end
endmodule
`default_nettype wire

/* sim/gsl_port_test.sv */
// self-checking bench for the gpio set/clear/latch port
`timescale 1ns/1ps
`default_nettype none
module gsl_port_test;
   logic        mclk, rst, rd, wr, wake, irq, wreq;
   logic [11:0] adr;
   logic [3:0]  be;
   logic [31:0] wd, rdat, pin_in, pin_out, oe_n, sd, swe, sdo, ext, q;
   int          err_total, checks;

   // clock and pin model
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   gsl_pins_model i_pins (.drv_i(pin_out), .oe_n_i(oe_n), .ext_i(ext), .pin_o(pin_in));
   gsl_port i_dut (.mclk_i(mclk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pin_in_i(pin_in),
      .pin_out_o(pin_out), .pin_oe_n_o(oe_n), .pin_setup_dir_i(sd),
      .pin_setup_dir_we_i(swe), .pin_setup_dir_o(sdo), .wake_o(wake), .irq_o(irq));

   // verdict and end of run
   task automatic wrap_up();
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one comparison of a 32-bit result
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic [11:0] a, input logic r, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      adr <= a;
      rd  <= r;
      wr  <= ~r;
      wd  <= d;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         chk(32'h1, 32'h0, "bus hang");
         wrap_up();
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      bus(a, 1'b0, d);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
      bus(a, 1'b1, 32'h0000_0000);
      chk(q, e, m);
   endtask

   task automatic wait_cy(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // reset values of the direction and latch state
   task automatic t_reset();
      chk(oe_n, 32'hFFFF_FFFF, "oe_n after reset");
      rchk(gsl_pkg::GSL_OE_MASK, 32'h0000_0000, "mask reset");
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0000, "latch reset");
      rchk(gsl_pkg::GSL_WAKE_SEL, 32'h0000_0000, "wake sel reset");
      rchk(gsl_pkg::GSL_OUT_SET, 32'h0000_0000, "out reset");
   endtask

   // output level set and clear, read back through both views
   task automatic t_out();
      wreg(gsl_pkg::GSL_OUT_SET, 32'hA5A5_0F0F);
      wreg(gsl_pkg::GSL_OUT_SET, 32'h0000_0000);
      rchk(gsl_pkg::GSL_OUT_CLR, 32'hA5A5_0F0F, "out via clr");
      wreg(gsl_pkg::GSL_OUT_CLR, 32'h8000_0F01);
      wait_cy(1);
      chk(pin_out, 32'h25A5_000E, "pin_out after clr");
      rchk(gsl_pkg::GSL_OUT_SET, 32'h25A5_000E, "out via set");
      be <= 4'h1;
      wreg(gsl_pkg::GSL_OUT_SET, 32'hFFFF_FFFF);
      be <= 4'hF;
      rchk(gsl_pkg::GSL_OUT_CLR, 32'h25A5_00FF, "byte lane set");
   endtask

   // direction set, clear, pin_setup path and an unmapped place
   task automatic t_dir();
      wreg(gsl_pkg::GSL_OE_SET, 32'h0000_00FF);
      wreg(gsl_pkg::GSL_OE_SET, 32'h0F00_0000);
      wreg(gsl_pkg::GSL_OE_CLR, 32'h0000_000F);
      rchk(gsl_pkg::GSL_OE_SET, 32'h0F00_00F0, "dir via set");
      rchk(gsl_pkg::GSL_OE_CLR, 32'h0F00_00F0, "dir via clr");
      chk(oe_n, 32'hF0FF_FF0F, "oe_n from mask");
      chk(sdo, 32'h0F00_00F0, "pin_setup dir view");
      @(posedge mclk);
      sd  <= 32'h0000_0001;
      swe <= 32'h0000_0011;
      @(posedge mclk);
      swe <= 32'h0000_0000;
      rchk(gsl_pkg::GSL_OE_MASK, 32'h0F00_00E1, "pin_setup write seen");
      rchk(12'h700, 32'h0000_0000, "unmapped read");
      wreg(12'h700, 32'hFFFF_FFFF);
      rchk(gsl_pkg::GSL_OE_MASK, 32'h0F00_00E1, "unmapped write");
   endtask

   // input state: driven pin echoes, released pins follow board; writes ignored
   task automatic t_input();
      ext <= 32'h1234_5678;
      wait_cy(4);
      rchk(gsl_pkg::GSL_IN_STATE, 32'h1534_56F9, "input state");
      wreg(gsl_pkg::GSL_OE_CLR, 32'hFFFF_FFFF);
      wreg(gsl_pkg::GSL_IN_STATE, 32'h0000_0000);
      rchk(gsl_pkg::GSL_IN_STATE, 32'h1234_5678, "input after write");
   endtask

   // pin0 high sense, pin1 low sense, pins 2 and 3 off (codes 0, 1)
   task automatic t_latch();
      ext <= 32'h0000_0002;
      wreg(gsl_pkg::GSL_SENSE_LO, 32'h0000_004E);
      wreg(gsl_pkg::GSL_HIT_LATCH, 32'hFFFF_FFFF);
      wait_cy(4);
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0000, "no hit");
      ext <= 32'h0000_000F;
      wait_cy(4);
      chk({31'h0, wake}, 32'h1, "live wake high");
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0001, "high hit");
      ext <= 32'h0000_0002;
      wait_cy(4);
      chk({31'h0, wake}, 32'h0, "live wake low");
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0001, "hit held");
      wreg(gsl_pkg::GSL_WAKE_SEL, 32'h0000_0001);
      wait_cy(4);
      chk({31'h0, wake}, 32'h1, "latched wake");
      ext <= 32'h0000_0000;
      wait_cy(4);
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0003, "low hit");
      wreg(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0001);
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0002, "clear one bit");
      ext <= 32'h0000_0002;
      wreg(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0002);
      rchk(gsl_pkg::GSL_HIT_LATCH, 32'h0000_0000, "clear last");
      wait_cy(4);
      chk({31'h0, wake}, 32'h0, "latched wake off");
      wreg(gsl_pkg::GSL_WAKE_SEL, 32'h0000_0000);
   endtask

   // sticky status, mask and level interrupt
   task automatic t_irq();
      wreg(gsl_pkg::GSL_INT_STATUS, 32'h0000_0003);
      wreg(gsl_pkg::GSL_INT_MASK, 32'h0000_0001);
      rchk(gsl_pkg::GSL_INT_STATUS, 32'h0000_0000, "status clear");
      chk({31'h0, irq}, 32'h0, "irq idle");
      ext <= 32'h0000_0003;
      wait_cy(5);
      chk({31'h0, irq}, 32'h1, "irq on hit");
      rchk(gsl_pkg::GSL_INT_STATUS, 32'h0000_0003, "status both");
      wreg(gsl_pkg::GSL_INT_MASK, 32'h0000_0000);
      wait_cy(1);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wreg(gsl_pkg::GSL_INT_MASK, 32'h0000_0002);
      ext <= 32'h0000_0002;
      wait_cy(4);
      chk({31'h0, irq}, 32'h1, "irq wake bit");
      wreg(gsl_pkg::GSL_INT_STATUS, 32'h0000_0002);
      wait_cy(1);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rchk(gsl_pkg::GSL_INT_STATUS, 32'h0000_0001, "status w1c");
   endtask

   // watchdog against a hang
   initial
   begin
      #20000;
      err_total++;
      $display("MISMATCH %0t watchdog expired", $time);
      wrap_up();
   end

   // reset then scenarios
   initial
   begin
      err_total = 0;
      checks = 0;
      rst = 1'b1;
      {rd, wr} = 2'b00;
      adr = 12'h000;
      be = 4'hF;
      {wd, sd, swe} = 96'h0;
      ext = 32'h0000_0000;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      wait_cy(1);
      t_reset();
      t_out();
      t_dir();
      t_input();
      t_latch();
      t_irq();
      wrap_up();
   end
endmodule
`default_nettype wire
